// ==== include/aperture_delay_pkg.sv ====
package aperture_delay_pkg;

  // ========================================
  // Register map (printed offsets)
  localparam logic [9:0] ADDR_CAL_ENABLE = 10'h2b0;
  localparam logic [9:0] ADDR_CAL_RESULT = 10'h2b2;
  localparam logic [9:0] ADDR_DELAY_SETTING = 10'h2b5;
  localparam logic [9:0] ADDR_RAMP_CONTROL = 10'h2b8;

  localparam int REG_WIDTH = 24;
  localparam logic [23:0] REG_RESET = 24'h00_0000;

  // ========================================
  // Field positions
  localparam int INVERT_BIT = 16;
  localparam int COARSE_LSB = 8;
  localparam int FINE_LSB = 0;
  localparam int DONE_BIT = 17;
  localparam int CAL_ENABLE_BIT = 0;
  localparam int RAMP_ENABLE_BIT = 0;
  localparam int RAMP_RATE_BIT = 1;

  // ========================================
  // Timing, in clock cycles, and ramp step sizes, in codes
  localparam int UPDATE_LATENCY_CYC = 1536;
  localparam int RAMP_PERIOD_CYC = 384;
  localparam logic [7:0] STEP_SLOW = 8'h01;
  localparam logic [7:0] STEP_FAST = 8'h04;

  // ========================================
  // Calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_DONE = 2'b10
  } cal_state_e;

endpackage : aperture_delay_pkg

// ==== rtl/aperture_delay_control.sv ====
// Overview of operation
// - Done bit reads one only with calibration enabled and calibration finished.
// - Calibrated 17-bit delay word reported; valid only while done reads one.
// - Result word: bit 16 invert, bits 15:8 coarse, bits 7:0 fine.
// - Manual invert bit set inverts the sampling clock.
// - Calibration off: manual coarse field drives the coarse delay.
// - Calibration off: manual fine field drives the fine delay.
// - Fine field accepts any value at any time, no sequencing.
// - Ramp mode moves the applied coarse delay gradually toward the target.
// - All manual delay fields reset to zero.
// - Calibration enabled: automatic delay used, manual register ignored.
// - Rising calibration enable launches the calibration sequence.
// - Ramp off: written coarse value applied within 1536 cycles.
// - Ramp on: coarse steps one or four codes every 384 cycles.
`timescale 1ns/1ns
`default_nettype none

module aperture_delay_control
  import aperture_delay_pkg::*;
#(
  parameter int RAMP_PERIOD = RAMP_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [9:0] regAddr,
  input wire logic [23:0] regWdata,
  output logic [23:0] regRdata,
  input wire logic calEngineDone,
  input wire logic [16:0] calEngineWord,
  output logic calStart,
  output logic sampleClockInvert,
  output logic [7:0] coarseDelay,
  output logic [7:0] fineDelay
);

  // ========================================
  // Elaboration checks
  if (RAMP_PERIOD < 1 || RAMP_PERIOD > 65535) begin : gBadPeriod
    $error("RAMP_PERIOD out of range");
  end

  // ========================================
  // Reset synchroniser
  logic [1:0] rstSync;
  logic rstn;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  assign rstn = rstSync[1];

  // ========================================
  // State
  typedef struct packed {
    logic invert;
    logic [7:0] coarseTarget;
    logic [7:0] fine;
    logic calEnable;
    logic rampEnable;
    logic rampFast;
    cal_state_e calState;
    logic [16:0] calWord;
    logic [7:0] coarseRamp;
    logic [15:0] rampCnt;
    logic [23:0] rdata;
    logic calStart;
    logic outInvert;
    logic [7:0] outCoarse;
    logic [7:0] outFine;
  } state_s;

  state_s st;
  state_s next_st;

  function automatic logic [7:0] stepToward(input logic [7:0] cur, input logic [7:0] tgt,
                                            input logic [7:0] step);
    logic [7:0] res;
    res = tgt;
    if (cur < tgt) begin
      if (8'(tgt - cur) > step) begin
        res = 8'(cur + step);
      end
    end else if (cur > tgt) begin
      if (8'(cur - tgt) > step) begin
        res = 8'(cur - step);
      end
    end
    return res;
  endfunction : stepToward

  logic done;
  logic rampTick;
  assign done = (st.calState == CAL_DONE);
  assign rampTick = (st.rampCnt == 16'(RAMP_PERIOD - 1));

  // ========================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.calStart = 1'b0;

    // Register writes
    if (regWrite) begin
      if (regAddr == ADDR_DELAY_SETTING) begin
        next_st.invert = regWdata[INVERT_BIT];
        next_st.coarseTarget = regWdata[COARSE_LSB +: 8];
        next_st.fine = regWdata[FINE_LSB +: 8];
      end else if (regAddr == ADDR_CAL_ENABLE) begin
        next_st.calEnable = regWdata[CAL_ENABLE_BIT];
        if (regWdata[CAL_ENABLE_BIT] && !st.calEnable) begin
          next_st.calStart = 1'b1;
          next_st.calState = CAL_RUN;
        end else if (!regWdata[CAL_ENABLE_BIT]) begin
          next_st.calState = CAL_IDLE;
        end
      end else if (regAddr == ADDR_RAMP_CONTROL) begin
        next_st.rampEnable = regWdata[RAMP_ENABLE_BIT];
        next_st.rampFast = regWdata[RAMP_RATE_BIT];
      end
    end

    // Calibration sequencer
    case (st.calState)
      CAL_RUN: begin
        if (calEngineDone && next_st.calState == CAL_RUN && !st.calStart) begin
          next_st.calState = CAL_DONE;
          next_st.calWord = calEngineWord;
        end
      end
      default: begin
      end
    endcase

    // Coarse ramp
    if (!st.rampEnable) begin
      next_st.rampCnt = '0;
      next_st.coarseRamp = st.coarseTarget;
    end else if (rampTick) begin
      next_st.rampCnt = '0;
      next_st.coarseRamp = stepToward(st.coarseRamp, st.coarseTarget,
                                      st.rampFast ? STEP_FAST : STEP_SLOW);
    end else begin
      next_st.rampCnt = 16'(st.rampCnt + 16'h0001);
    end

    // Applied delay selection
    if (st.calEnable) begin
      next_st.outInvert = st.calWord[INVERT_BIT];
      next_st.outCoarse = st.calWord[COARSE_LSB +: 8];
      next_st.outFine = st.calWord[FINE_LSB +: 8];
    end else begin
      next_st.outInvert = st.invert;
      next_st.outCoarse = st.coarseRamp;
      next_st.outFine = st.fine;
    end

    // Register reads
    next_st.rdata = '0;
    if (regRead) begin
      if (regAddr == ADDR_DELAY_SETTING) begin
        next_st.rdata[INVERT_BIT] = st.invert;
        next_st.rdata[COARSE_LSB +: 8] = st.coarseTarget;
        next_st.rdata[FINE_LSB +: 8] = st.fine;
      end else if (regAddr == ADDR_CAL_RESULT) begin
        next_st.rdata[DONE_BIT] = done;
        next_st.rdata[INVERT_BIT:FINE_LSB] = st.calWord;
      end else if (regAddr == ADDR_CAL_ENABLE) begin
        next_st.rdata[CAL_ENABLE_BIT] = st.calEnable;
      end else if (regAddr == ADDR_RAMP_CONTROL) begin
        next_st.rdata[RAMP_ENABLE_BIT] = st.rampEnable;
        next_st.rdata[RAMP_RATE_BIT] = st.rampFast;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign regRdata = st.rdata;
  assign calStart = st.calStart;
  assign sampleClockInvert = st.outInvert;
  assign coarseDelay = st.outCoarse;
  assign fineDelay = st.outFine;

  // ========================================
  // Assertions
  AST_DONE_NEEDS_EN: assert property (@(posedge clk_sys) disable iff (!rstn)
    done |-> st.calEnable)
    else $error("Done set while calibration disabled");

  AST_RESULT_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
    (regRead && regAddr == ADDR_CAL_RESULT) |=>
      regRdata == {6'h00, $past(done), $past(st.calWord)})
    else $error("Result read mismatch");

  AST_CAL_APPLY: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st.calEnable && done) ##1 (st.calEnable && done) |->
      {sampleClockInvert, coarseDelay, fineDelay} == $past(st.calWord))
    else $error("Calibrated word not applied");

  AST_MANUAL_INVERT: assert property (@(posedge clk_sys) disable iff (!rstn)
    !st.calEnable |=> sampleClockInvert == $past(st.invert))
    else $error("Invert not applied");

  AST_MANUAL_FINE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (regWrite && regAddr == ADDR_DELAY_SETTING && !st.calEnable && !next_st.calEnable)
      |-> ##2 fineDelay == $past(regWdata[7:0], 2))
    else $error("Fine value not applied in two cycles");

  AST_IMMEDIATE_COARSE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !st.rampEnable ##1 !st.calEnable |=> coarseDelay == $past(st.coarseTarget, 2))
    else $error("Coarse not applied promptly");

  AST_RAMP_STEP: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st.rampEnable && st.coarseRamp != $past(st.coarseRamp) && $past(st.rampEnable)) |->
      ($past(rampTick) && (st.coarseRamp - $past(st.coarseRamp) <= 8'h04
       || $past(st.coarseRamp) - st.coarseRamp <= 8'h04)))
    else $error("Ramp step too large or off tick");

  AST_LAUNCH: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(st.calEnable) |-> st.calStart && st.calState == CAL_RUN)
    else $error("Rising enable did not launch calibration");

  AST_DONE_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st.calStart || !st.calEnable) |-> !done)
    else $error("Done not cleared");

  AST_IGNORE_MANUAL: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st.calEnable && $past(st.calEnable)) |=> fineDelay == $past(st.calWord[7:0]))
    else $error("Manual register not ignored");

  AST_START_PULSE: assert property (@(posedge clk_sys) disable iff (!rstn)
    calStart |=> !calStart)
    else $error("Calibration start longer than one cycle");

  AST_NO_RELAUNCH: assert property (@(posedge clk_sys) disable iff (!rstn)
    (regWrite && regAddr == ADDR_CAL_ENABLE && regWdata[CAL_ENABLE_BIT] && st.calEnable)
      |=> !calStart)
    else $error("Calibration relaunched while enabled");

  AST_DONE_SOURCE: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(done) |-> $past(calEngineDone) && $past(st.calState) == CAL_RUN)
    else $error("Done set without finished calibration");

  AST_DISABLE_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (regWrite && regAddr == ADDR_CAL_ENABLE && !regWdata[CAL_ENABLE_BIT])
      |=> st.calState == CAL_IDLE && !done)
    else $error("Disable did not clear calibration state");

  AST_RESULT_READ_ONLY: assert property (@(posedge clk_sys) disable iff (!rstn)
    (regWrite && regAddr == ADDR_CAL_RESULT && st.calState != CAL_RUN)
      |=> $stable(st.calWord))
    else $error("Result word changed by a register write");

  AST_FINE_ANY_TIME: assert property (@(posedge clk_sys) disable iff (!rstn)
    (regWrite && regAddr == ADDR_DELAY_SETTING)
      |=> st.fine == $past(regWdata[FINE_LSB +: 8]))
    else $error("Fine field write not taken");

  AST_RAMP_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st.rampEnable && !rampTick) |=> st.coarseRamp == $past(st.coarseRamp))
    else $error("Ramp moved between ticks");

  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !regRead |=> regRdata == 24'h00_0000)
    else $error("Read data not zero without a read");

  COV_CAL_DONE: cover property (@(posedge clk_sys) disable iff (!rstn)
    st.calStart ##[1:50] done);

  COV_RAMP_STEP: cover property (@(posedge clk_sys) disable iff (!rstn)
    st.rampEnable && rampTick && st.coarseRamp != st.coarseTarget);

  COV_MANUAL_INVERT: cover property (@(posedge clk_sys) disable iff (!rstn)
    !st.calEnable && $rose(sampleClockInvert));

  COV_RAMP_FAST: cover property (@(posedge clk_sys) disable iff (!rstn)
    st.rampEnable && st.rampFast && rampTick && st.coarseRamp != st.coarseTarget);

  COV_RELAUNCH: cover property (@(posedge clk_sys) disable iff (!rstn)
    $fell(st.calEnable) ##[1:20] st.calStart);

endmodule : aperture_delay_control

`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin \
  $display("unexpected %s exp %h got %h", nm, e, a); failures++; end end

module tb;
  import aperture_delay_pkg::*;
  localparam int RP = 8;
  typedef struct {string name; logic [23:0] exp;} note_s;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic [23:0] regWdata = 24'h00_0000;
  logic [23:0] regRdata;
  logic calEngineDone = 1'b0;
  logic [16:0] calEngineWord = 17'h0_0000;
  logic calStart;
  logic sampleClockInvert;
  logic [7:0] coarseDelay;
  logic [7:0] fineDelay;
  note_s notes[$];
  note_s cur;
  int failures = 0;
  int n_tests = 0;
  int seed = 32'he02c;
  logic rdPend = 1'b0;
  logic [23:0] manual;
  logic [16:0] word;

  aperture_delay_control #(.RAMP_PERIOD(RP)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .calEngineDone(calEngineDone), .calEngineWord(calEngineWord),
    .calStart(calStart), .sampleClockInvert(sampleClockInvert),
    .coarseDelay(coarseDelay), .fineDelay(fineDelay));

  // ========================================
  // Clock and read-result monitor
  always #25 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (rdPend) begin
      if (notes.size() == 0) begin
        `CHK("regRdata", 24'h00_0000, 24'hff_ffff)
      end else begin
        cur = notes.pop_front();
        `CHK(cur.name, cur.exp, regRdata)
      end
    end
    rdPend <= regRead;
  end

  // ========================================
  // Bus and check tasks
  task automatic complete_run;
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [9:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input string nm, input logic [23:0] e);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    notes.push_back('{nm, e});
    @(posedge clk_sys);
    regRead <= 1'b0;
  endtask : rd

  task automatic chk_out(input logic inv, input logic [7:0] c, input logic [7:0] f);
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("sampleClockInvert", inv, sampleClockInvert)
    `CHK("coarseDelay", c, coarseDelay)
    `CHK("fineDelay", f, fineDelay)
  endtask : chk_out

  task automatic ramp(input logic [7:0] t, input int step, input int nSteps, input int bound);
    int i;
    int changes;
    int last;
    logic [7:0] prev;
    #1;
    prev = coarseDelay;
    changes = 0;
    last = 0;
    for (i = 0; i < bound && coarseDelay !== t; i++) begin
      @(posedge clk_sys);
      #1;
      if (coarseDelay !== prev) begin
        changes++;
        `CHK("coarseStep", 1'b1, ((coarseDelay > prev) ? coarseDelay - prev : prev - coarseDelay) <= step)
        `CHK("rampPace", 1'b1, (changes < 2 || i - last >= RP))
        last = i;
      end
      prev = coarseDelay;
    end
    `CHK("coarseDelay", t, coarseDelay)
    `CHK("rampSteps", nSteps, changes)
    if (coarseDelay !== t) complete_run();
  endtask : ramp

  task automatic cal_launch;
    int i;
    wr(ADDR_CAL_ENABLE, 24'h00_0001);
    #1;
    for (i = 0; i < 4 && calStart !== 1'b1; i++) @(posedge clk_sys) #1;
    `CHK("calStart", 1'b1, calStart)
  endtask : cal_launch

  // ========================================
  // Main sequence
  initial begin
    #(50 * 20000);
    `CHK("timeout", 1'b0, 1'b1)
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(ADDR_DELAY_SETTING, "delayReset", REG_RESET);
    chk_out(1'b0, 8'h00, 8'h00);
    rd(10'h3ff, "unmapped", 24'h00_0000);
    manual = {7'h00, 17'($random(seed))};
    wr(ADDR_DELAY_SETTING, manual);
    chk_out(manual[16], manual[15:8], manual[7:0]);
    rd(ADDR_DELAY_SETTING, "delaySetting", manual);
    for (int k = 0; k < 4; k++) begin
      manual[7:0] = 8'($random(seed));
      wr(ADDR_DELAY_SETTING, manual);
      chk_out(manual[16], manual[15:8], manual[7:0]);
    end
    manual[15:8] = 8'h40;
    wr(ADDR_DELAY_SETTING, manual);
    ramp(8'h40, 255, (manual[15:8] == coarseDelay) ? 0 : 1, UPDATE_LATENCY_CYC);
    wr(ADDR_RAMP_CONTROL, 24'h00_0001);
    manual[15:8] = 8'h45;
    wr(ADDR_DELAY_SETTING, manual);
    ramp(8'h45, 1, 5, 10 * RP);
    wr(ADDR_RAMP_CONTROL, 24'h00_0003);
    manual[15:8] = 8'h36;
    wr(ADDR_DELAY_SETTING, manual);
    ramp(8'h36, 4, 4, 10 * RP);
    wr(ADDR_RAMP_CONTROL, 24'h00_0000);
    for (int k = 0; k < 2; k++) begin
      manual[15:8] = manual[15:8] + 8'h01;
      wr(ADDR_DELAY_SETTING, manual);
      chk_out(manual[16], manual[15:8], manual[7:0]);
    end
    wr(ADDR_CAL_RESULT, 24'hff_ffff);
    cal_launch();
    rd(ADDR_CAL_RESULT, "calPending", 24'h00_0000);
    word = 17'($random(seed));
    @(posedge clk_sys);
    calEngineDone <= 1'b1;
    calEngineWord <= word;
    @(posedge clk_sys);
    calEngineDone <= 1'b0;
    rd(ADDR_CAL_RESULT, "calResult", {6'h00, 1'b1, word});
    chk_out(word[16], word[15:8], word[7:0]);
    manual = {7'h00, ~word};
    wr(ADDR_DELAY_SETTING, manual);
    @(posedge clk_sys);
    calEngineDone <= 1'b1;
    calEngineWord <= ~word;
    @(posedge clk_sys);
    calEngineDone <= 1'b0;
    chk_out(word[16], word[15:8], word[7:0]);
    rd(ADDR_CAL_RESULT, "calHeld", {6'h00, 1'b1, word});
    wr(ADDR_CAL_ENABLE, 24'h00_0000);
    rd(ADDR_CAL_RESULT, "calOff", {7'h00, word});
    chk_out(manual[16], manual[15:8], manual[7:0]);
    cal_launch();
    rd(ADDR_CAL_RESULT, "calRelaunch", {7'h00, word});
    repeat (3) @(posedge clk_sys);
    complete_run();
  end
endmodule : tb
`default_nettype wire
